// ===== logic/fsa_fault_supervisor.v
/*
  fault supervisor: latches limit-check results into an active fault set,
  drives lamps, keys lockout, display codes, alarm tone, recorder zeroing,
  valves and emission, with an axi4-lite register slave.
  assumes limit comparators and panel keys are synchronous to sys_clk_in.
*/
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`include "fsa_regs.vh"

module fsa_fault_supervisor #(
  parameter ROT_CYC   = `FSA_ROT_CYC,
  parameter STEP_CYC  = `FSA_STEP_CYC,
  parameter HLO_CYC   = `FSA_HLO_CYC,
  parameter HHI_CYC   = `FSA_HHI_CYC,
  parameter BLINK_CYC = `FSA_BLINK_CYC,
  parameter CW        = 32
) (
  // clock and reset
  input  wire        sys_clk_in,
  input  wire        sys_rst_in,
  // limit-check results, one level per monitor
  input  wire        ref_above_in,
  input  wire        ref_below_in,
  input  wire        battery_low_in,
  input  wire        option_high_in,
  input  wire        option_low_in,
  input  wire        hand_unit_supply_low_in,
  input  wire        amp_hot_in,
  input  wire        amp_cold_in,
  input  wire        low_supply_flag_in,
  input  wire        anode_cathode_high_in,
  input  wire        anode_cathode_low_in,
  input  wire        suppressor_high_in,
  input  wire        suppressor_low_in,
  input  wire        anode_under_nominal_in,
  // operator keys and remote inputs
  input  wire        clear_key_in,
  input  wire        remote_ack_in,
  input  wire        start_key_in,
  input  wire        stop_key_in,
  input  wire        trigger_in_in,
  input  wire [2:0]  trigger_state_in,
  input  wire        watchdog_restart_in,
  // operator outputs
  output reg         hand_lamps_out,
  output reg  [7:0]  exponent_code_out,
  output reg         start_cmd_out,
  output reg         stop_cmd_out,
  output reg  [2:0]  trigger_leds_out,
  output reg  [7:0]  msg_letter_out,
  output reg  [7:0]  msg_number_out,
  output reg         tone_out,
  output reg         recorder_zero_out,
  output reg         fail_relay_out,
  output reg         valve_2a_open_out,
  output reg         other_valves_close_out,
  output reg         emission_off_out,
  output reg         standby_out,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  localparam NF = `FSA_NFAULT;
  localparam [NF-1:0] WARN_M = `FSA_WARN_MASK;
  localparam [NF-1:0] HU_M   = `FSA_HU_MASK;
  localparam [NF-1:0] EMIS_M = `FSA_EMIS_MASK;
  localparam [8*NF-1:0] CODES = `FSA_CODE_TABLE;

  // ----------------------------------------------------------------
  // fault set
  // ----------------------------------------------------------------
  wire [NF-1:0] raw_w;
  reg  [NF-1:0] active_r;
  reg  [NF-1:0] active_nxt;
  reg  [3:0]    ctrl_r;
  reg  [15:0]   log_cnt_r;
  reg  [3:0]    sel_r;
  reg  [3:0]    sel_nxt;
  reg  [CW-1:0] rot_cnt_r;
  reg  [CW-1:0] step_cnt_r;
  reg  [CW-1:0] half_cnt_r;
  reg  [CW-1:0] blink_cnt_r;
  reg           tone_hi_r;
  reg           blink_r;
  reg           clear_d_r;
  reg           ack_d_r;
  reg           sw_ack_r;
  integer       i;
  reg  [31:0]   rot_idx;

  assign raw_w[`FSA_F_REF_HI] = ref_above_in;
  assign raw_w[`FSA_F_REF_LO] = ref_below_in;
  assign raw_w[`FSA_F_BATT]   = battery_low_in;
  assign raw_w[`FSA_F_OPT_HI] = option_high_in;
  assign raw_w[`FSA_F_OPT_LO] = option_low_in;
  assign raw_w[`FSA_F_HU_SUP] = hand_unit_supply_low_in;
  assign raw_w[`FSA_F_AMP_HI] = amp_hot_in;
  assign raw_w[`FSA_F_AMP_LO] = amp_cold_in;
  assign raw_w[`FSA_F_LOWSUP] = low_supply_flag_in;
  assign raw_w[`FSA_F_AC_HI]  = anode_cathode_high_in;
  assign raw_w[`FSA_F_AC_LO]  = anode_cathode_low_in;
  assign raw_w[`FSA_F_SUP_HI] = suppressor_high_in;
  assign raw_w[`FSA_F_SUP_LO] = suppressor_low_in;
  assign raw_w[`FSA_F_AN_LO]  = anode_under_nominal_in;

  // acknowledge is edge-triggered so a held key cannot clear a new fault
  wire ack_w = (clear_key_in & ~clear_d_r) | (remote_ack_in & ~ack_d_r) | sw_ack_r;
  wire sys_err_w = ctrl_r[`FSA_CTRL_SYSERR];
  wire [NF-1:0] err_w = active_r & ~WARN_M;
  wire err_any_w = (|err_w) | sys_err_w;

  always @*
  begin
    active_nxt = active_r | raw_w;
    if (ack_w)
    begin
      // warnings and errors alike clear on ack, but only when their cause is gone
      active_nxt = (active_r & ~WARN_M & raw_w) | raw_w;
    end
  end

  // ----------------------------------------------------------------
  // rotation over active codes
  // ----------------------------------------------------------------
  always @*
  begin
    sel_nxt = sel_r;
    rot_idx = 32'h00000000;
    // scan downwards so the nearest active code after sel_r wins
    for (i = NF - 1; i >= 0; i = i - 1)
    begin
      rot_idx = (sel_r + 1 + i) % NF;
      if (active_r[rot_idx])
        sel_nxt = rot_idx[3:0];
    end
  end

  wire       cur_act_w  = active_r[sel_r];
  wire [7:0] cur_code_w = CODES[8*sel_r +: 8];

  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      active_r    <= {NF{1'b0}};
      sel_r       <= 4'h0;
      rot_cnt_r   <= {CW{1'b0}};
      clear_d_r   <= 1'b0;
      ack_d_r     <= 1'b0;
      log_cnt_r   <= 16'h0000;
    end
    else
    begin
      clear_d_r <= clear_key_in;
      ack_d_r   <= remote_ack_in;
      active_r  <= active_nxt;
      // faults that appear while a system error is set are not logged
      if (|(active_nxt & ~active_r) && !sys_err_w)
        log_cnt_r <= log_cnt_r + 16'h0001;
      if (!cur_act_w || rot_cnt_r >= ROT_CYC - 1)
      begin
        rot_cnt_r <= {CW{1'b0}};
        sel_r     <= sel_nxt;
      end
      else
        rot_cnt_r <= rot_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // alarm tone and lamp blink
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in || !err_any_w)
    begin
      step_cnt_r  <= {CW{1'b0}};
      half_cnt_r  <= {CW{1'b0}};
      blink_cnt_r <= {CW{1'b0}};
      tone_hi_r   <= 1'b0;
      blink_r     <= 1'b0;
      tone_out    <= 1'b0;
    end
    else
    begin
      if (step_cnt_r >= STEP_CYC - 1)
      begin
        step_cnt_r <= {CW{1'b0}};
        tone_hi_r  <= ~tone_hi_r;
      end
      else
        step_cnt_r <= step_cnt_r + 1'b1;
      if (half_cnt_r >= (tone_hi_r ? HHI_CYC : HLO_CYC) - 1)
      begin
        half_cnt_r <= {CW{1'b0}};
        tone_out   <= ~tone_out;
      end
      else
        half_cnt_r <= half_cnt_r + 1'b1;
      if (blink_cnt_r >= BLINK_CYC - 1)
      begin
        blink_cnt_r <= {CW{1'b0}};
        blink_r     <= ~blink_r;
      end
      else
        blink_cnt_r <= blink_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // fault response outputs
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      hand_lamps_out         <= 1'b0;
      exponent_code_out      <= 8'h00;
      start_cmd_out          <= 1'b0;
      stop_cmd_out           <= 1'b0;
      trigger_leds_out       <= 3'h0;
      msg_letter_out         <= 8'h00;
      msg_number_out         <= 8'h00;
      recorder_zero_out      <= 1'b0;
      fail_relay_out         <= 1'b0;
      valve_2a_open_out      <= 1'b0;
      other_valves_close_out <= 1'b0;
      emission_off_out       <= 1'b0;
      standby_out            <= 1'b1;
    end
    else
    begin
      hand_lamps_out <= err_any_w ? blink_r : 1'b1;
      exponent_code_out <= (|(err_w & HU_M)) ? CODES[8*`FSA_F_HU_SUP +: 8] : 8'h00;
      start_cmd_out  <= start_key_in & ~err_any_w;
      stop_cmd_out   <= stop_key_in & ~err_any_w;
      trigger_leds_out <= err_any_w ? 3'h0 : trigger_state_in;
      recorder_zero_out <= err_any_w;
      fail_relay_out <= err_any_w;
      valve_2a_open_out <= err_any_w;
      other_valves_close_out <= err_any_w;
      emission_off_out <= sys_err_w | (|(err_w & EMIS_M)) |
                          (ctrl_r[`FSA_CTRL_EMIS] & err_any_w);
      standby_out <= ~err_any_w;
      if (sys_err_w)
      begin
        msg_letter_out <= `FSA_CH_E;
        msg_number_out <= `FSA_SYS_CODE;
      end
      else if (cur_act_w)
      begin
        msg_letter_out <= WARN_M[sel_r] ? `FSA_CH_W : `FSA_CH_E;
        msg_number_out <= cur_code_w;
      end
      else
      begin
        msg_letter_out <= 8'h00;
        msg_number_out <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave, single outstanding write and read
  // ----------------------------------------------------------------
  reg        aw_hold_r;
  reg        w_hold_r;
  reg [7:0]  awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;
  wire       wr_go_w = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  wire       wr_ok_w = (awaddr_r == `FSA_OFS_CTRL);

  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      ctrl_r        <= `FSA_CTRL_RESET;
      sw_ack_r      <= 1'b0;
    end
    else
    begin
      sw_ack_r      <= 1'b0;
      s_axi_awready <= ~aw_hold_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_hold_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go_w)
      begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok_w ? 2'b00 : 2'b10;
        if (wr_ok_w && wstrb_r[0])
        begin
          ctrl_r   <= {wdata_r[3], wdata_r[2], wdata_r[1], 1'b0};
          sw_ack_r <= wdata_r[`FSA_CTRL_ACK];
        end
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // watchdog restart drops system error state, no code reported
      if (watchdog_restart_in)
        ctrl_r[`FSA_CTRL_SYSERR] <= 1'b0;
    end
  end

  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `FSA_OFS_STATUS:  s_axi_rdata <= {29'h0, standby_out, sys_err_w, err_any_w};
          `FSA_OFS_ACTIVE:  s_axi_rdata <= {18'h0, active_r};
          `FSA_OFS_RAW:     s_axi_rdata <= {18'h0, raw_w};
          `FSA_OFS_CTRL:    s_axi_rdata <= {28'h0, ctrl_r};
          `FSA_OFS_DISPLAY: s_axi_rdata <= {16'h0, msg_letter_out, msg_number_out};
          `FSA_OFS_LOG:     s_axi_rdata <= {16'h0, log_cnt_r};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== logic/fsa_regs.vh
/*
  constants for the fault supervisor: register offsets, fault bit positions,
  message codes, timing counts and reset values.
  assumes a 125 MHz system clock and an axi4-lite master in the same domain.
*/
`ifndef FSA_REGS_VH
`define FSA_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FSA_OFS_STATUS   8'h00
`define FSA_OFS_ACTIVE   8'h04
`define FSA_OFS_RAW      8'h08
`define FSA_OFS_CTRL     8'h0c
`define FSA_OFS_DISPLAY  8'h10
`define FSA_OFS_LOG      8'h14

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define FSA_CTRL_ACK     0
`define FSA_CTRL_SYSERR  1
`define FSA_CTRL_WDOG    2
`define FSA_CTRL_EMIS    3
`define FSA_CTRL_RESET   4'h8

// ----------------------------------------------------------------
// fault set: bit index and message number
// ----------------------------------------------------------------
`define FSA_NFAULT       14
`define FSA_F_REF_HI     0
`define FSA_F_REF_LO     1
`define FSA_F_BATT       2
`define FSA_F_OPT_HI     3
`define FSA_F_OPT_LO     4
`define FSA_F_HU_SUP     5
`define FSA_F_AMP_HI     6
`define FSA_F_AMP_LO     7
`define FSA_F_LOWSUP     8
`define FSA_F_AC_HI      9
`define FSA_F_AC_LO      10
`define FSA_F_SUP_HI     11
`define FSA_F_SUP_LO     12
`define FSA_F_AN_LO      13
// warnings carry no error effects; hand unit fault shows on the exponent
`define FSA_WARN_MASK    14'h0084
`define FSA_HU_MASK      14'h0020
// ion source supply faults kill emission; supply and temperature errors kill it only while FSA_CTRL_EMIS is set, as it is at reset
`define FSA_EMIS_MASK    14'h3e00
`define FSA_CODE_TABLE   112'h41_39_38_36_35_34_33_32_30_24_23_22_21_20
`define FSA_SYS_CODE     8'h10

// ----------------------------------------------------------------
// ascii letters
// ----------------------------------------------------------------
`define FSA_CH_E         8'h45
`define FSA_CH_W         8'h57

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FSA_CLK_HZ       125000000
`define FSA_ROT_MS       2000
`define FSA_TONE_STEP_MS 400
`define FSA_TONE_LO_HZ   500
`define FSA_TONE_HI_HZ   1200
`define FSA_ROT_CYC      ((`FSA_CLK_HZ / 1000) * `FSA_ROT_MS)
`define FSA_STEP_CYC     ((`FSA_CLK_HZ / 1000) * `FSA_TONE_STEP_MS)
`define FSA_HLO_CYC      (`FSA_CLK_HZ / (2 * `FSA_TONE_LO_HZ))
`define FSA_HHI_CYC      (`FSA_CLK_HZ / (2 * `FSA_TONE_HI_HZ))
`define FSA_BLINK_CYC    ((`FSA_CLK_HZ / 1000) * 250)
`endif

// ===== tb/fsa_panel_model.sv
/*
  operator panel and remote connector keys facing the fault supervisor.
  assumes the bench pulses ack_req_in for one cycle to ask for a press.
*/
module fsa_panel_model (
  input  wire        sys_clk_in,
  input  wire        ack_req_in,
  input  wire        use_remote_in,
  input  wire  [3:0] delay_in,
  output logic       clear_key_out,
  output logic       remote_ack_out,
  output logic [2:0] trigger_state_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int   wait_r = -1;
  int   hold_r = 0;
  logic remote_r = 1'b0;

  // released keys are pulled low, so an idle key never reads high
  assign clear_key_out     = (hold_r > 0) && !remote_r;
  assign remote_ack_out    = (hold_r > 0) && remote_r;
  assign trigger_state_out = 3'b101;

  // a slow operator presses only after delay_in cycles
  always @(posedge sys_clk_in)
  begin
    if (ack_req_in)
    begin
      wait_r   <= delay_in;
      remote_r <= use_remote_in;
    end
    else if (wait_r > 0)
      wait_r <= wait_r - 1;
    else if (wait_r == 0)
    begin
      hold_r <= 2;
      wait_r <= -1;
    end
    else if (hold_r > 0)
      hold_r <= hold_r - 1;
  end
endmodule

// ===== tb/fsa_sup_checker.sv
/*
  checker for the fault supervisor ports, bound into every instance.
  assumes the blink parameter equals that of the instance it watches.
*/
module fsa_sup_checker #(
  parameter BLINK_CYC = 4
) (
  input wire       sys_clk_in,
  input wire       sys_rst_in,
  input wire       amp_hot_in,
  input wire       anode_cathode_high_in,
  input wire       hand_unit_supply_low_in,
  input wire       hand_lamps_out,
  input wire [7:0] exponent_code_out,
  input wire       start_cmd_out,
  input wire       stop_cmd_out,
  input wire [2:0] trigger_leds_out,
  input wire [7:0] msg_letter_out,
  input wire       tone_out,
  input wire       recorder_zero_out,
  input wire       fail_relay_out,
  input wire       valve_2a_open_out,
  input wire       other_valves_close_out,
  input wire       emission_off_out,
  input wire       standby_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // ----------------------------------------------------------------
  // cycles since lamps or tone last moved while in error
  // ----------------------------------------------------------------
  logic [31:0] lamp_cnt_r;
  logic [3:0] tone_cnt_r;
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in || !recorder_zero_out || $changed(hand_lamps_out))
      lamp_cnt_r <= 4'h0;
    else if (lamp_cnt_r != 32'hffffffff)
      lamp_cnt_r <= lamp_cnt_r + 32'h1;
    if (sys_rst_in || !recorder_zero_out || $changed(tone_out))
      tone_cnt_r <= 4'h0;
    else if (tone_cnt_r != 4'hf)
      tone_cnt_r <= tone_cnt_r + 4'h1;
  end

  sequence s_amp_rise;
    $rose(amp_hot_in) && !recorder_zero_out;
  endsequence
  sequence s_hu_rise;
    $rose(hand_unit_supply_low_in) && !recorder_zero_out;
  endsequence
  property p_flash;
    lamp_cnt_r < BLINK_CYC + 3;
  endproperty
  property p_hu_code;
    s_hu_rise |-> ##2 exponent_code_out == 8'h30;
  endproperty
  property p_keys;
    recorder_zero_out |-> !start_cmd_out && !stop_cmd_out;
  endproperty
  property p_leds;
    recorder_zero_out |-> trigger_leds_out == 3'b000;
  endproperty
  property p_tone;
    tone_cnt_r < 4'h8;
  endproperty
  property p_err_out;
    s_amp_rise |-> ##2 recorder_zero_out && fail_relay_out;
  endproperty
  property p_valves;
    valve_2a_open_out == recorder_zero_out && other_valves_close_out == recorder_zero_out;
  endproperty
  property p_emis;
    $rose(anode_cathode_high_in) |-> ##2 emission_off_out;
  endproperty
  property p_standby;
    $fell(sys_rst_in) |-> standby_out && !recorder_zero_out;
  endproperty
  property p_letter;
    msg_letter_out == 8'h00 || msg_letter_out == 8'h45 || msg_letter_out == 8'h57;
  endproperty

  a_flash: assert property (p_flash) else $error("lamps not flashing");
  a_hu_code: assert property (p_hu_code) else $error("no exponent code");
  a_keys: assert property (p_keys) else $error("keys not locked");
  a_leds: assert property (p_leds) else $error("trigger leds lit");
  a_tone: assert property (p_tone) else $error("tone stuck");
  a_err_out: assert property (p_err_out) else $error("recorder not zeroed");
  a_valves: assert property (p_valves) else $error("valves wrong");
  a_emis: assert property (p_emis) else $error("emission left on");
  a_standby: assert property (p_standby) else $error("no standby");
  a_letter: assert property (p_letter) else $error("bad letter");
endmodule

bind fsa_fault_supervisor fsa_sup_checker #(
  .BLINK_CYC(BLINK_CYC)
) u_chk (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .amp_hot_in(amp_hot_in),
  .anode_cathode_high_in(anode_cathode_high_in),
  .hand_unit_supply_low_in(hand_unit_supply_low_in), .hand_lamps_out(hand_lamps_out),
  .exponent_code_out(exponent_code_out), .start_cmd_out(start_cmd_out),
  .stop_cmd_out(stop_cmd_out), .trigger_leds_out(trigger_leds_out),
  .msg_letter_out(msg_letter_out), .tone_out(tone_out),
  .recorder_zero_out(recorder_zero_out), .fail_relay_out(fail_relay_out),
  .valve_2a_open_out(valve_2a_open_out), .other_valves_close_out(other_valves_close_out),
  .emission_off_out(emission_off_out), .standby_out(standby_out)
);

// ===== tb/fsa_testbench.sv
/*
  self-checking bench for the fault supervisor with shortened timing.
  assumes fsa_regs.vh on the include path and the panel model beside it.
*/
`include "fsa_regs.vh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [13:0] flt = 14'h0000;
  logic        start_key_in = 1'b0, stop_key_in = 1'b0, trigger_in_in = 1'b0;
  logic        watchdog_restart_in = 1'b0, ack_req = 1'b0, use_remote = 1'b0;
  logic [3:0]  ack_dly = 4'h0;
  wire         clear_key_in, remote_ack_in, hand_lamps_out, start_cmd_out, stop_cmd_out;
  wire         tone_out, recorder_zero_out, fail_relay_out, valve_2a_open_out;
  wire         other_valves_close_out, emission_off_out, standby_out;
  wire  [2:0]  trigger_state_in, trigger_leds_out;
  wire  [7:0]  exponent_code_out, msg_letter_out, msg_number_out;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  int          mismatches = 0;
  int          n_checks = 0;

  fsa_fault_supervisor #(
    .ROT_CYC(20), .STEP_CYC(8), .HLO_CYC(3), .HHI_CYC(2), .BLINK_CYC(4)
  ) dut (
    .ref_above_in(flt[0]), .ref_below_in(flt[1]), .battery_low_in(flt[2]),
    .option_high_in(flt[3]), .option_low_in(flt[4]), .hand_unit_supply_low_in(flt[5]),
    .amp_hot_in(flt[6]), .amp_cold_in(flt[7]), .low_supply_flag_in(flt[8]),
    .anode_cathode_high_in(flt[9]), .anode_cathode_low_in(flt[10]),
    .suppressor_high_in(flt[11]), .suppressor_low_in(flt[12]),
    .anode_under_nominal_in(flt[13]), .*
  );

  fsa_panel_model panel (
    .sys_clk_in(sys_clk_in), .ack_req_in(ack_req), .use_remote_in(use_remote),
    .delay_in(ack_dly), .clear_key_out(clear_key_in), .remote_ack_out(remote_ack_in),
    .trigger_state_out(trigger_state_in)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timeout();
    mismatches++;
    $display("unexpected at %0t: no answer", $time);
    tally_and_finish();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge sys_clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (++n > 50)
        timeout();
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge sys_clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (++n > 50)
        timeout();
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic press_ack(input logic remote, input logic [3:0] dly);
    @(posedge sys_clk_in);
    use_remote <= remote;
    ack_dly <= dly;
    ack_req <= 1'b1;
    @(posedge sys_clk_in);
    ack_req <= 1'b0;
    cyc(int'(dly) + 8);
  endtask

  task automatic until_change(output int n);
    logic [7:0] prev = msg_number_out;
    n = 0;
    do
    begin
      @(posedge sys_clk_in);
      if (++n > 100)
        timeout();
    end while (msg_number_out === prev);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    check(standby_out, 1'b1);
    axi_read(`FSA_OFS_CTRL, d, r);
    check(d, `FSA_CTRL_RESET);
    axi_read(8'h18, d, r);
    check({d[29:0], r}, 32'h2);
    axi_write(`FSA_OFS_STATUS, 32'h1, r);
    check(r, 2'b10);
    $display("reset test done");
  endtask

  // each fault alone, acknowledged by either key after its cause is gone
  task automatic t_table();
    logic [13:0]  wm = `FSA_WARN_MASK;
    logic [13:0]  em = `FSA_EMIS_MASK;
    logic [111:0] ct = `FSA_CODE_TABLE;
    logic [1:0]   r;
    axi_write(`FSA_OFS_CTRL, 32'h0, r);
    for (int i = 0; i < `FSA_NFAULT; i++)
    begin
      @(posedge sys_clk_in);
      flt[i] <= 1'b1;
      cyc(4);
      check(msg_letter_out, wm[i] ? `FSA_CH_W : `FSA_CH_E);
      check(msg_number_out, ct[8*i +: 8]);
      check(recorder_zero_out, !wm[i]);
      check(valve_2a_open_out, !wm[i]);
      check(trigger_leds_out, wm[i] ? 3'b101 : 3'b000);
      check(emission_off_out, em[i]);
      check(exponent_code_out, i == `FSA_F_HU_SUP ? 8'h30 : 8'h00);
      @(posedge sys_clk_in);
      flt[i] <= 1'b0;
      press_ack(i[0], i[0] ? 4'h3 : 4'h0);
      check(msg_letter_out, 8'h00);
      check(standby_out, 1'b1);
    end
    $display("fault table test done");
  endtask

  task automatic t_refuse();
    @(posedge sys_clk_in);
    flt[6] <= 1'b1;
    start_key_in <= 1'b1;
    stop_key_in <= 1'b1;
    cyc(4);
    press_ack(1'b0, 4'h0);
    check(recorder_zero_out, 1'b1);
    check(start_cmd_out | stop_cmd_out, 1'b0);
    @(posedge sys_clk_in);
    flt[6] <= 1'b0;
    press_ack(1'b1, 4'h1);
    check(recorder_zero_out, 1'b0);
    check(start_cmd_out, 1'b1);
    check(trigger_leds_out, 3'b101);
    @(posedge sys_clk_in);
    start_key_in <= 1'b0;
    stop_key_in <= 1'b0;
    $display("refuse test done");
  endtask

  task automatic t_rotate();
    int         n;
    logic [7:0] first;
    @(posedge sys_clk_in);
    flt[0] <= 1'b1;
    flt[6] <= 1'b1;
    until_change(n);
    first = msg_number_out;
    until_change(n);
    check(n, 20);
    check(msg_number_out ^ first, 8'h20 ^ 8'h32);
    @(posedge sys_clk_in);
    flt <= 14'h0000;
    press_ack(1'b0, 4'h2);
    check(recorder_zero_out, 1'b0);
    $display("rotate test done");
  endtask

  task automatic t_warning();
    @(posedge sys_clk_in);
    flt[2] <= 1'b1;
    cyc(3);
    flt[2] <= 1'b0;
    cyc(10);
    check(msg_letter_out, `FSA_CH_W);
    check(msg_number_out, 8'h22);
    check(recorder_zero_out, 1'b0);
    press_ack(1'b1, 4'h2);
    check(msg_letter_out, 8'h00);
    $display("warning test done");
  endtask

  task automatic t_syserr();
    logic [1:0] r;
    axi_write(`FSA_OFS_CTRL, 32'h2, r);
    check(r, 2'b00);
    cyc(4);
    check(recorder_zero_out, 1'b1);
    check(msg_number_out, `FSA_SYS_CODE);
    check(emission_off_out, 1'b1);
    press_ack(1'b0, 4'h0);
    check(recorder_zero_out, 1'b1);
    @(posedge sys_clk_in);
    watchdog_restart_in <= 1'b1;
    @(posedge sys_clk_in);
    watchdog_restart_in <= 1'b0;
    cyc(4);
    check(standby_out, 1'b1);
    check(msg_letter_out, 8'h00);
    check(recorder_zero_out, 1'b0);
    // emission switch-off by control bit, then acknowledge by software
    @(posedge sys_clk_in);
    flt[0] <= 1'b1;
    axi_write(`FSA_OFS_CTRL, 32'h8, r);
    cyc(4);
    check(emission_off_out, 1'b1);
    @(posedge sys_clk_in);
    flt[0] <= 1'b0;
    axi_write(`FSA_OFS_CTRL, 32'h9, r);
    cyc(4);
    check(recorder_zero_out, 1'b0);
    check(standby_out, 1'b1);
    $display("system error test done");
  endtask

  initial
  begin
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  initial
  begin
    repeat (16) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_table();
    t_refuse();
    t_rotate();
    t_warning();
    t_syserr();
    tally_and_finish();
  end
endmodule
